// ==== srw_pkg.sv ====
// constants shared by the supervisor reset and watchdog block
package srw_pkg;

  // =====================================================================
  // clock and timebase
  // =====================================================================
  localparam int CLK_HZ       = 20_000_000;  // system clock rate
  localparam int OSC_HZ       = 10_240;      // internal oscillator rate
  localparam int OSC_DIV      = CLK_HZ / OSC_HZ;  // clocks per internal tick
  localparam int CNT_W        = 16;          // width of tick counters

  // =====================================================================
  // times in their own unit, and tick counts derived from them
  // =====================================================================
  localparam int RST_STD_MS   = 50;          // reset active, standard part
  localparam int RST_LONG_MS  = 200;         // reset active, long-reset part
  localparam int WD_FAST_MS   = 100;         // short watchdog timeout
  localparam int WD_SLOW_MS   = 1600;        // long watchdog timeout, 1.6 s
  localparam int RST_STD_TK   = RST_STD_MS * OSC_HZ / 1000;
  localparam int RST_LONG_TK  = RST_LONG_MS * OSC_HZ / 1000;
  localparam int WD_FAST_TK   = WD_FAST_MS * OSC_HZ / 1000;
  localparam int WD_SLOW_TK   = WD_SLOW_MS * OSC_HZ / 1000;

  // terminal counts in timebase cycles when the timebase pin drives timing
  localparam int EXT_WD_NORM  = 1024;
  localparam int EXT_WD_POST  = 4096;
  localparam int EXT_RST_STD  = 512;
  localparam int EXT_RST_LONG = 2048;

  // =====================================================================
  // service input levels
  // =====================================================================
  typedef enum logic [1:0] {
    SRW_SVC_MID  = 2'h0,
    SRW_SVC_LOW  = 2'h1,
    SRW_SVC_HIGH = 2'h2
  } srw_svc_e;

  // =====================================================================
  // register map, byte addresses
  // =====================================================================
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS   = 8'h04;
  localparam logic [ADR_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [ADR_W-1:0] REG_IRQ_MASK = 8'h0c;

  localparam int CTRL_WD_EN   = 0;           // watchdog enable bit
  localparam logic CTRL_RST   = 1'h1;        // watchdog enabled after reset

  localparam int EV_W         = 3;           // event bits
  localparam int EV_SUPPLY    = 0;           // supply fell below threshold
  localparam int EV_TIMEOUT   = 1;           // watchdog expired
  localparam int EV_BACKUP    = 2;           // backup supply taken over
  localparam logic [EV_W-1:0] EV_NONE = 3'h0;

  localparam int ST_RESET     = 0;           // status bit positions
  localparam int ST_WDS       = 1;
  localparam int ST_BACKUP    = 2;
  localparam int ST_LONG      = 3;
  localparam int ST_EXT       = 4;
  localparam int ST_FAST      = 5;
  localparam int ST_SVC       = 6;           // two bits, 7:6

endpackage

// ==== srw_tick_if.sv ====
// timebase ticks and sampled service level passed to the supervisor core
`timescale 1ns/100ps
interface srw_tick_if;
  logic               tick;      // one-cycle pulse per timebase period
  logic               ext_mode;  // timing taken from the timebase pin
  logic               fast_sel;  // short normal timeout selected
  srw_pkg::srw_svc_e  svc;       // service level, sampled on ticks

  modport gen (output tick, output ext_mode, output fast_sel, output svc);
  modport sink (input tick, input ext_mode, input fast_sel, input svc);
endinterface

// ==== srw_timebase.sv ====
// timebase source selection, tick generation and service sampling
`timescale 1ns/100ps
module srw_timebase #(
  parameter int OSC_DIV = srw_pkg::OSC_DIV
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  en_i,
  input  wire logic  timebase_sel_i,
  input  wire logic  timebase_i,
  input  wire logic  service_hi_i,
  input  wire logic  service_lo_i,
  srw_tick_if.gen    tb
);
  import srw_pkg::*;

  logic [CNT_W-1:0] div_q;
  logic             tb_s1_q, tb_s2_q, tb_s3_q;
  logic             div_hit, ext_edge;

  // timebase pin may be a free clock: two flops, then a third for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_s1_q <= 1'h0;
      tb_s2_q <= 1'h0;
      tb_s3_q <= 1'h0;
    end else if (en_i) begin
      tb_s1_q <= timebase_i;
      tb_s2_q <= tb_s1_q;
      tb_s3_q <= tb_s2_q;
    end
  end

  assign ext_edge = tb_s2_q & ~tb_s3_q;
  assign div_hit  = (div_q == CNT_W'(OSC_DIV - 1));

  // internal oscillator stand-in: divide the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else if (en_i) begin
      div_q <= div_hit ? '0 : div_q + 1'h1;
    end
  end

  // select source, register tick and mode so each is a clean flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb.tick     <= 1'h0;
      tb.ext_mode <= 1'h0;
      tb.fast_sel <= 1'h0;
    end else if (en_i) begin
      tb.ext_mode <= ~timebase_sel_i;
      tb.tick     <= timebase_sel_i ? div_hit : ext_edge;
      tb.fast_sel <= timebase_sel_i & ~tb_s2_q;
    end
  end

  // service level taken once per tick so edges live on the timebase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb.svc <= SRW_SVC_MID;
    end else if (en_i && (timebase_sel_i ? div_hit : ext_edge)) begin
      if (service_hi_i && !service_lo_i) begin
        tb.svc <= SRW_SVC_HIGH;
      end else if (service_lo_i && !service_hi_i) begin
        tb.svc <= SRW_SVC_LOW;
      end else begin
        tb.svc <= SRW_SVC_MID;
      end
    end
  end

endmodule

// ==== srw_supervisor.sv ====
// supervisor core: supply reset, reset stretch, watchdog, backup flag, wishbone
//
// What this block does
// - active-high reset is complement of active-low
// - select high or floating uses internal oscillator
// - select low times from timebase pin
// - internal reset period 50 or 200 ms
// - internal mode: timebase level picks normal timeout
// - after reset, timeout is long: 1.6 s internal, 4096 timebase cycles external
// - steady service past timeout drives status low
// - next service transition returns status high
// - midsupply service disables watchdog, status high
// - supply low forces watchdog status high
// - backup mode with 50/70 mV hysteresis
// - supply below threshold asserts reset immediately
// - hold reset for active period after recovery
// - every service transition restarts watchdog count
// - timeout also issues reset active pulse
// - normal timeout only after first post-reset transition
// - timebase high selects 1.6 s, low 100 ms
`timescale 1ns/100ps
module srw_supervisor #(
  parameter bit LONG_RESET  = 1'b0,                  // long-reset variant
  parameter int OSC_DIV     = srw_pkg::OSC_DIV,
  parameter int RST_STD_TK  = srw_pkg::RST_STD_TK,
  parameter int RST_LONG_TK = srw_pkg::RST_LONG_TK,
  parameter int WD_FAST_TK  = srw_pkg::WD_FAST_TK,
  parameter int WD_SLOW_TK  = srw_pkg::WD_SLOW_TK
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      en_i,
  // comparator and strap inputs
  input  wire logic                      supply_low_i,
  input  wire logic                      backup_near_i,
  input  wire logic                      backup_clear_i,
  input  wire logic                      timebase_sel_i,
  input  wire logic                      timebase_i,
  input  wire logic                      service_hi_i,
  input  wire logic                      service_lo_i,
  // outputs to the host
  output logic                           reset_n_o,
  output logic                           reset_o,
  output logic                           watchdog_status_out_o,
  output logic                           backup_active_flag_o,
  output logic                           irq_o,
  // wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [srw_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o
);
  import srw_pkg::*;

  // =====================================================================
  // timebase
  // =====================================================================
  srw_tick_if tb ();

  srw_timebase #(
    .OSC_DIV        (OSC_DIV)
  ) u_timebase (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .en_i           (en_i),
    .timebase_sel_i (timebase_sel_i),
    .timebase_i     (timebase_i),
    .service_hi_i   (service_hi_i),
    .service_lo_i   (service_lo_i),
    .tb             (tb.gen)
  );

  // =====================================================================
  // declarations
  // =====================================================================
  logic [CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic [CNT_W-1:0] wd_cnt_q;
  logic [CNT_W-1:0] rst_lim, wd_lim;
  logic             in_reset_q, in_reset_d;
  logic             long_q;
  logic             wds_q;
  logic             backup_q;
  logic             supply_low_q;
  srw_svc_e         svc_prev_q;
  logic             svc_edge, wd_active, timeout;
  logic             ctrl_wd_en_q;
  logic [EV_W-1:0]  irq_stat_q, irq_mask_q, events, w1c;
  logic             req, wr_fire, rd_fire;
  logic [31:0]      rd_data;

  // =====================================================================
  // terminal counts
  // =====================================================================
  // one counter serves both sources; only the terminal counts differ
  always_comb begin
    if (tb.ext_mode) begin
      rst_lim = LONG_RESET ? CNT_W'(EXT_RST_LONG) : CNT_W'(EXT_RST_STD);
      if (long_q) begin
        wd_lim = CNT_W'(EXT_WD_POST);
      end else begin
        wd_lim = CNT_W'(EXT_WD_NORM);
      end
    end else begin
      rst_lim = LONG_RESET ? CNT_W'(RST_LONG_TK) : CNT_W'(RST_STD_TK);
      if (long_q || !tb.fast_sel) begin
        wd_lim = CNT_W'(WD_SLOW_TK);
      end else begin
        wd_lim = CNT_W'(WD_FAST_TK);
      end
    end
  end

  // =====================================================================
  // watchdog edge and timeout detection
  // =====================================================================
  // an edge is any change onto a driven level; mid means watchdog off
  assign svc_edge  = tb.tick && (tb.svc != svc_prev_q)
                     && (tb.svc != SRW_SVC_MID);
  assign wd_active = ctrl_wd_en_q && !in_reset_q
                     && (tb.svc != SRW_SVC_MID);
  // >= so a limit that shrinks mid-count still expires
  assign timeout   = tb.tick && wd_active && !svc_edge
                     && (wd_cnt_q >= wd_lim - 1'h1);

  // previous sampled service level, moved only on ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      svc_prev_q <= SRW_SVC_MID;
    end else if (en_i && tb.tick) begin
      svc_prev_q <= tb.svc;
    end
  end

  // watchdog counter: restarts on edges and while held off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt_q <= '0;
    end else if (en_i) begin
      if (!wd_active || svc_edge || timeout) begin
        wd_cnt_q <= '0;
      end else if (tb.tick) begin
        wd_cnt_q <= wd_cnt_q + 1'h1;
      end
    end
  end

  // long timeout armed by any reset, dropped on first later edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      long_q <= 1'h1;
    end else if (en_i) begin
      if (in_reset_q) begin
        long_q <= 1'h1;
      end else if (svc_edge) begin
        long_q <= 1'h0;
      end
    end
  end

  // =====================================================================
  // reset generation
  // =====================================================================
  // supply low overrides everything; the stretch counts only above threshold
  always_comb begin
    in_reset_d = in_reset_q;
    rst_cnt_d  = rst_cnt_q;
    if (supply_low_i) begin
      in_reset_d = 1'h1;
      rst_cnt_d  = '0;
    end else if (timeout) begin
      in_reset_d = 1'h1;
      rst_cnt_d  = '0;
    end else if (in_reset_q && tb.tick) begin
      if (rst_cnt_q >= rst_lim - 1'h1) begin
        in_reset_d = 1'h0;
        rst_cnt_d  = '0;
      end else begin
        rst_cnt_d  = rst_cnt_q + 1'h1;
      end
    end
  end

  // both polarities come from the same next value, so they never disagree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_reset_q <= 1'h1;
      rst_cnt_q  <= '0;
      reset_n_o  <= 1'h0;
      reset_o    <= 1'h1;
    end else if (en_i) begin
      in_reset_q <= in_reset_d;
      rst_cnt_q  <= rst_cnt_d;
      reset_n_o  <= ~in_reset_d;
      reset_o    <= in_reset_d;
    end
  end

  // =====================================================================
  // watchdog status output
  // =====================================================================
  // forcing terms win over a timeout in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wds_q <= 1'h1;
    end else if (en_i) begin
      if (supply_low_i) begin
        wds_q <= 1'h1;
      end else if (tb.svc == SRW_SVC_MID) begin
        wds_q <= 1'h1;
      end else if (svc_edge) begin
        wds_q <= 1'h1;
      end else if (timeout) begin
        wds_q <= 1'h0;
      end
    end
  end

  assign watchdog_status_out_o = wds_q;

  // =====================================================================
  // backup supply indicator
  // =====================================================================
  // the comparators give the two margins; entry wins if both are seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      backup_q <= 1'h0;
    end else if (en_i) begin
      if (backup_near_i) begin
        backup_q <= 1'h1;
      end else if (backup_clear_i) begin
        backup_q <= 1'h0;
      end
    end
  end

  assign backup_active_flag_o = backup_q;

  // =====================================================================
  // events and interrupt
  // =====================================================================
  // supply event on the falling edge of the supply only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_low_q <= 1'h0;
    end else if (en_i) begin
      supply_low_q <= supply_low_i;
    end
  end

  assign events[EV_SUPPLY]  = supply_low_i & ~supply_low_q;
  assign events[EV_TIMEOUT] = timeout;
  assign events[EV_BACKUP]  = backup_near_i & ~backup_q;

  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ~wb_ack_o;
  assign rd_fire = req & ~wb_we_i & ~wb_ack_o;
  assign w1c     = (wr_fire && wb_sel_i[0] && wb_adr_i == REG_IRQ_STAT)
                   ? wb_dat_i[EV_W-1:0] : EV_NONE;

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= EV_NONE;
    end else if (en_i) begin
      irq_stat_q <= (irq_stat_q & ~w1c) | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'h0;
    end else if (en_i) begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // =====================================================================
  // wishbone slave
  // =====================================================================
  // writable registers use byte lane 0 only; upper lanes have no bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_wd_en_q <= CTRL_RST;
      irq_mask_q   <= EV_NONE;
    end else if (en_i && wr_fire && wb_sel_i[0]) begin
      if (wb_adr_i == REG_CTRL) begin
        ctrl_wd_en_q <= wb_dat_i[CTRL_WD_EN];
      end
      if (wb_adr_i == REG_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[EV_W-1:0];
      end
    end
  end

  // read mux; unmapped addresses answer with zero
  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      REG_CTRL: begin
        rd_data[CTRL_WD_EN] = ctrl_wd_en_q;
      end
      REG_STATUS: begin
        rd_data[ST_RESET]           = in_reset_q;
        rd_data[ST_WDS]             = wds_q;
        rd_data[ST_BACKUP]          = backup_q;
        rd_data[ST_LONG]            = long_q;
        rd_data[ST_EXT]             = tb.ext_mode;
        rd_data[ST_FAST]            = tb.fast_sel;
        rd_data[ST_SVC+1:ST_SVC]    = tb.svc;
      end
      REG_IRQ_STAT: begin
        rd_data[EV_W-1:0] = irq_stat_q;
      end
      REG_IRQ_MASK: begin
        rd_data[EV_W-1:0] = irq_mask_q;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  // one wait state: ack a cycle after the strobe, drop it a cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= '0;
    end else if (en_i) begin
      wb_ack_o <= req & ~wb_ack_o;
      if (rd_fire) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule

// ==== srw_supervisor_sva.sv ====
// concurrent checks on the supervisor top-level ports
`timescale 1ns/100ps
module srw_supervisor_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic supply_low_i,
  input wire logic backup_near_i,
  input wire logic backup_clear_i,
  input wire logic service_hi_i,
  input wire logic service_lo_i,
  input wire logic reset_n_o,
  input wire logic reset_o,
  input wire logic watchdog_status_out_o,
  input wire logic backup_active_flag_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  // =====================================================================
  // one clock domain; a reset pulse voids checks still in flight
  // =====================================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_compl; reset_o == !reset_n_o; endproperty
  a_compl: assert property (p_compl)
    else $error("reset outputs not complementary");
  property p_low_rst; en_i && supply_low_i |=> !reset_n_o; endproperty
  a_low_rst: assert property (p_low_rst)
    else $error("reset not asserted on low supply");
  property p_low_wds; en_i && supply_low_i |=> watchdog_status_out_o; endproperty
  a_low_wds: assert property (p_low_wds)
    else $error("status not forced high on low supply");
  // the shortest stretch in use is far above eight cycles
  property p_stretch; $fell(supply_low_i) |-> !reset_n_o [*8]; endproperty
  a_stretch: assert property (p_stretch)
    else $error("reset released too early");
  property p_enter; en_i && backup_near_i |=> backup_active_flag_o; endproperty
  a_enter: assert property (p_enter)
    else $error("backup mode not entered");
  property p_leave;
    en_i && backup_clear_i && !backup_near_i |=> !backup_active_flag_o;
  endproperty
  a_leave: assert property (p_leave)
    else $error("backup mode not left");
  // inside the hysteresis band the mode must not chatter
  property p_hyst;
    en_i && !backup_near_i && !backup_clear_i |=> $stable(backup_active_flag_o);
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("backup mode chattered");
  property p_wds_rst; $fell(watchdog_status_out_o) |-> ##[0:3] !reset_n_o; endproperty
  a_wds_rst: assert property (p_wds_rst)
    else $error("timeout without reset pulse");
  // sixteen cycles cover a tick period plus sampling in either timing mode
  property p_mid;
    (service_hi_i == service_lo_i) [*8] ##1 (service_hi_i == service_lo_i) [*8]
      |-> watchdog_status_out_o;
  endproperty
  a_mid: assert property (p_mid)
    else $error("status low with service at midsupply");
  property p_ack; en_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not acknowledged");
  property p_ack1; en_i && wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1)
    else $error("bus acknowledge longer than one cycle");
endmodule

// ==== srw_host_model.sv ====
// host side model: drives the three-level service pin and the timebase pin
`timescale 1ns/100ps
module srw_host_model (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ext_i,
  input  wire logic              lvl_i,
  input  wire srw_pkg::srw_svc_e svc_i,
  output logic                   timebase_o,
  output logic                   service_hi_o,
  output logic                   service_lo_o
);
  import srw_pkg::*;
  logic [2:0] div_q;
  // free-running divider, slow enough for a two-flop sync to see each edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign timebase_o   = ext_i ? div_q[2] : lvl_i;
  // pre-decoded level; both lines low reads as midsupply
  assign service_hi_o = (svc_i == SRW_SVC_HIGH);
  assign service_lo_o = (svc_i == SRW_SVC_LOW);
endmodule

// ==== srw_supervisor_tb.sv ====
// self-checking bench for the supervisor reset and watchdog block
`timescale 1ns/100ps
module srw_supervisor_tb;
  import srw_pkg::*;
  logic             clk_i, rst_i, en_i, supply_low_i, backup_near_i, backup_clear_i;
  logic             timebase_sel_i, timebase_i, service_hi_i, service_lo_i, ext_run, tb_lvl;
  logic             reset_n_o, reset_o, watchdog_status_out_o, backup_active_flag_o, irq_o;
  logic             wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i, wb_dat_o;
  srw_svc_e         svc;
  int               bad_count, check_count;

  // short tick counts keep the run brief; expectations scale with them
  srw_supervisor #(.OSC_DIV(4), .RST_STD_TK(8), .RST_LONG_TK(16), .WD_FAST_TK(16),
    .WD_SLOW_TK(64)) i_dut (
    .clk_i, .rst_i, .en_i, .supply_low_i, .backup_near_i, .backup_clear_i, .timebase_sel_i,
    .timebase_i, .service_hi_i, .service_lo_i, .reset_n_o, .reset_o, .watchdog_status_out_o,
    .backup_active_flag_o, .irq_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o);
  srw_host_model i_host (.clk_i, .rst_i, .ext_i(ext_run), .lvl_i(tb_lvl), .svc_i(svc),
    .timebase_o(timebase_i), .service_hi_o(service_hi_i), .service_lo_o(service_lo_i));

  always #25 clk_i = ~clk_i;

  // =====================================================================
  // compare, wait and bus helpers
  // =====================================================================
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // bounded wait; values are read before this edge's updates land
  task automatic till(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    rng("wait limit", 0, 4999, n);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    till(wb_ack_o, 1'b1, n);
    q = wb_dat_o;
    chk("wb ack", 1, wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse_supply;
    supply_low_i <= 1'b1;
    @(posedge clk_i);
    supply_low_i <= 1'b0;
    @(posedge clk_i);
    chk("reset_n_o", 0, reset_n_o);
    chk("reset_o", 1, reset_o);
    chk("wds on low supply", 1, watchdog_status_out_o);
  endtask

  // =====================================================================
  // scenarios
  // =====================================================================
  task automatic t_reset_state;
    logic [31:0] q;
    chk("reset_n_o", 0, reset_n_o);
    chk("wds", 1, watchdog_status_out_o);
    wb(1'b0, REG_CTRL, 0, q);
    chk("ctrl", 1, q);
    wb(1'b0, REG_IRQ_MASK, 0, q);
    chk("mask", 0, q);
    wb(1'b0, 8'h40, 0, q);
    chk("unmapped", 0, q);
    wb(1'b0, REG_STATUS, 0, q);
    chk("internal fast", 32'h20, q & 32'h30);
  endtask
  task automatic t_power_up;
    int n;
    supply_low_i <= 1'b0;
    @(posedge clk_i);
    till(reset_n_o, 1'b1, n);
    rng("power-up stretch", 28, 40, n);
  endtask
  // service held high from reset: only the long timeout may fire
  task automatic t_post_reset;
    int n;
    svc <= SRW_SVC_HIGH;
    repeat (20) @(posedge clk_i);
    pulse_supply();
    till(reset_n_o, 1'b1, n);
    till(watchdog_status_out_o, 1'b0, n);
    rng("post-reset timeout", 248, 272, n);
    repeat (4) @(posedge clk_i);
    till(reset_n_o, 1'b1, n);
    rng("timeout reset pulse", 22, 40, n);
    pulse_supply();
    till(reset_n_o, 1'b1, n);
  endtask
  task automatic t_normal(input logic lv, input int tk);
    int n;
    int m;
    tb_lvl <= lv;
    repeat (8) @(posedge clk_i);
    svc <= (svc == SRW_SVC_HIGH) ? SRW_SVC_LOW : SRW_SVC_HIGH;
    till(watchdog_status_out_o, 1'b1, n);
    rng("wds back high", 0, 8, n);
    till(watchdog_status_out_o, 1'b0, m);
    rng("normal timeout", tk * 4 - 4, tk * 4 + 12, n + m);
    repeat (4) @(posedge clk_i);
    till(reset_n_o, 1'b1, n);
  endtask
  // steady toggling inside the short timeout, then a long midsupply stretch
  task automatic t_service;
    int bad;
    bad = 0;
    tb_lvl <= 1'b0;
    for (int i = 0; i < 640; i++) begin
      if (i < 240 && i % 40 == 0) begin
        svc <= (svc == SRW_SVC_HIGH) ? SRW_SVC_LOW : SRW_SVC_HIGH;
      end
      if (i == 240) begin
        svc <= SRW_SVC_MID;
      end
      @(posedge clk_i);
      if (i > 20 && watchdog_status_out_o !== 1'b1) begin
        bad++;
      end
    end
    chk("wds low cycles", 0, bad);
  endtask
  task automatic t_irq;
    logic [31:0] q;
    wb(1'b1, REG_CTRL, 0, q);
    svc <= SRW_SVC_LOW;
    repeat (99) @(posedge clk_i);
    chk("watchdog off", 1, watchdog_status_out_o);
    wb(1'b0, REG_IRQ_STAT, 0, q);
    chk("events latched", 32'h3, q & 32'h3);
    chk("irq masked", 0, irq_o);
    wb(1'b1, REG_IRQ_MASK, 32'h3, q);
    chk("irq raised", 1, irq_o);
    wb(1'b1, REG_IRQ_STAT, 32'h7, q);
    wb(1'b0, REG_IRQ_STAT, 0, q);
    chk("events cleared", 0, q);
    chk("irq cleared", 0, irq_o);
    wb(1'b1, REG_IRQ_MASK, 32'h4, q);
  endtask
  task automatic t_backup;
    logic [31:0] q;
    backup_clear_i <= 1'b0;
    backup_near_i  <= 1'b1;
    @(posedge clk_i);
    backup_near_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("backup held", 1, backup_active_flag_o);
    chk("backup irq", 1, irq_o);
    wb(1'b0, REG_STATUS, 0, q);
    chk("status backup", 32'h4, q & 32'h4);
    backup_clear_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("backup left", 0, backup_active_flag_o);
  endtask
  task automatic t_external;
    int n;
    logic [31:0] q;
    timebase_sel_i <= 1'b0;
    ext_run        <= 1'b1;
    repeat (40) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 0, q);
    chk("external mode", 32'h10, q & 32'h10);
    pulse_supply();
    till(reset_n_o, 1'b1, n);
    rng("external reset period", 4070, 4120, n);
  endtask

  task automatic conclude;
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    {rst_i, en_i, supply_low_i, backup_clear_i, timebase_sel_i} = 5'h1f;
    {clk_i, backup_near_i, ext_run, tb_lvl, wb_cyc_i, wb_stb_i, wb_we_i} = 7'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    svc = SRW_SVC_MID;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_state();
    t_power_up();
    t_post_reset();
    t_normal(1'b0, 16);
    t_normal(1'b1, 64);
    t_service();
    t_irq();
    t_backup();
    t_external();
    conclude();
  end
  // a hang is cut short well after the longest expected run
  initial begin
    repeat (12000) @(posedge clk_i);
    bad_count++;
    conclude();
  end
endmodule

bind srw_supervisor srw_supervisor_sva i_sva (.clk_i, .rst_i, .en_i, .supply_low_i,
  .backup_near_i, .backup_clear_i, .service_hi_i, .service_lo_i, .reset_n_o, .reset_o,
  .watchdog_status_out_o, .backup_active_flag_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
